/* File: hdl/sram_host_pkg.sv */
package sram_host_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;

    // ------------------------------------------------------------
    // Timing, in ns as printed, and cycle counts at 200 MHz
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS      = 5000;
    localparam int WRITE_TO_FLOAT_NS  = 18;
    localparam int DATA_SETUP_NS      = 25;
    localparam int WRITE_PULSE_NS     = 35;
    localparam int READ_ACCESS_NS     = 45;
    localparam int BUS_TURN_NS        = 18;

    // Least times round up, and never fall below one cycle
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // Strobe-low width covers float delay plus data setup
    localparam int WR_LOW_CYC  = (min_cycles(WRITE_TO_FLOAT_NS + DATA_SETUP_NS)
                                  > min_cycles(WRITE_PULSE_NS))
                                 ? min_cycles(WRITE_TO_FLOAT_NS + DATA_SETUP_NS)
                                 : min_cycles(WRITE_PULSE_NS);
    localparam int RD_CYC      = min_cycles(READ_ACCESS_NS);
    localparam int TURN_CYC    = min_cycles(BUS_TURN_NS);
    // Pin to capture: one edge of margin, three sampler stages, agreement flop
    localparam int SYNC_CYC    = 5;
    localparam int CNT_W       = 4;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              write;
        logic [1:0]        lanes;   // [1] upper, [0] lower
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } req_t;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic              corrected;
    } rsp_t;

    typedef struct packed {
        logic select_low_active;
        logic select_high_active;
        logic write_n;
        logic output_n;
        logic upper_byte_strobe_n;
        logic lower_byte_strobe_n;
    } strobe_t;

    localparam strobe_t STROBE_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage

/* File: hdl/sram_sync3.sv */
`timescale 1ns/100ps
// Three-stage pin sampler; a change counts once stages two and three agree
module sram_sync3
#(
    parameter int W = 1
)
(
    // Clock
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;

    // ------------------------------------------------------------
    // Shift chain; first stage feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end
        else if (ce)
        begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Agreement filter holds last settled value
    always_ff @(posedge clk)
    begin
        if (rst)
            q <= '0;
        else if (ce)
        begin
            for (int i = 0; i < W; i++)
            begin
                if (s2_ff[i] == s3_ff[i])
                    q[i] <= s3_ff[i];
            end
        end
    end

endmodule

/* File: hdl/sram_host.sv */
`timescale 1ns/100ps
// Function
// - Write starts only with select and at least one byte strobe active
// - Data setup/hold referenced to terminating edge
// - Write strobe low covers float plus setup
// - Select pins always at valid levels
module sram_host
(
    // Clock and reset
    input  wire logic                          CLK,
    input  wire logic                          RST,
    input  wire logic                          CE,
    // User request
    input  wire logic                          REQ_VALID,
    output logic                               REQ_READY,
    input  wire sram_host_pkg::req_t           REQ,
    // User response
    output logic                               RSP_VALID,
    output sram_host_pkg::rsp_t                RSP,
    // Memory strobes and address
    output sram_host_pkg::strobe_t             MEM_STROBE,
    output logic [sram_host_pkg::ADDR_W-1:0]   MEM_ADDR,
    // Memory data bus, enable low while driving
    input  wire logic [sram_host_pkg::DATA_W-1:0] MEM_DQ_IN,
    output logic [sram_host_pkg::DATA_W-1:0]   MEM_DQ_OUT,
    output logic [sram_host_pkg::DATA_W-1:0]   MEM_DQ_OE_N,
    // Memory error flag
    input  wire logic                          MEM_ERR
);

    import sram_host_pkg::*;

    // Idle, strobes held for the access, then bus turnaround
    typedef enum {ST_IDLE, ST_WRITE, ST_READ, ST_TURN} state_t;

    state_t            state_ff;
    logic [CNT_W-1:0]  cnt_ff;
    req_t              req_ff;
    strobe_t           strobe_ff;
    logic [DATA_W-1:0] oe_n_ff;
    logic [DATA_W-1:0] dq_sync;
    logic              err_sync;
    logic              accept;
    logic              cnt_last;

    // Pin inputs; the error flag rides the same sampler as its data,
    // so both are seen with the same delay
    sram_sync3 #(.W(DATA_W + 1)) u_sync
    (
        .clk (CLK),
        .rst (RST),
        .ce  (CE),
        .d   ({MEM_ERR, MEM_DQ_IN}),
        .q   ({err_sync, dq_sync})
    );

    // Lane mask: expand two byte enables to sixteen bits
    function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] lanes);
        return {{LANE_W{lanes[1]}}, {LANE_W{lanes[0]}}};
    endfunction

    // ------------------------------------------------------------
    // Decode shared by the processes below
    // ------------------------------------------------------------
    // A request is taken in idle; CE is checked by each process
    assign accept   = (state_ff == ST_IDLE) && REQ_VALID;
    // Last cycle of the current phase
    assign cnt_last = (cnt_ff == CNT_W'(1));

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Only idle accepts; an all-zero lane request is harmless standby
    // Ready is combinational, so a waiting request goes out on the next edge
    assign REQ_READY = (state_ff == ST_IDLE) && CE;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state_ff <= ST_IDLE;
            cnt_ff   <= '0;
            req_ff   <= '0;
        end
        else if (CE)
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (REQ_VALID)
                    begin
                        req_ff   <= REQ;
                        // write low covers float plus setup
                        // Reads stay open for access time plus the sampler's delay,
                        // so the captured word is the settled one
                        cnt_ff   <= REQ.write ? CNT_W'(WR_LOW_CYC) : CNT_W'(RD_CYC + SYNC_CYC);
                        state_ff <= REQ.write ? ST_WRITE : ST_READ;
                    end
                end
                ST_WRITE, ST_READ:
                begin
                    // Strobes stay put until the count reaches one
                    if (cnt_ff == CNT_W'(1))
                    begin
                        cnt_ff   <= CNT_W'(TURN_CYC);
                        state_ff <= ST_TURN;
                    end
                    else
                        cnt_ff <= cnt_ff - CNT_W'(1);
                end
                ST_TURN:
                begin
                    // Lets device output float before next access
                    if (cnt_ff == CNT_W'(1))
                        state_ff <= ST_IDLE;
                    else
                        cnt_ff <= cnt_ff - CNT_W'(1);
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Strobes
    // ------------------------------------------------------------
    // All strobes leave on one edge, so whichever ends the write,
    // data and address still stand past it
    always_ff @(posedge CLK)
    begin
        if (RST)
            strobe_ff <= STROBE_IDLE;
        else if (CE)
        begin
            strobe_ff <= STROBE_IDLE;
            if (accept)
            begin
                strobe_ff.select_low_active   <= 1'b0;
                strobe_ff.select_high_active  <= 1'b1;
                strobe_ff.upper_byte_strobe_n <= ~REQ.lanes[1];
                strobe_ff.lower_byte_strobe_n <= ~REQ.lanes[0];
                // write strobe with select
                // A write with no lane keeps the write strobe high, so no
                // write ever starts without a byte strobe beside it
                strobe_ff.write_n             <= ~(REQ.write && (|REQ.lanes));
                strobe_ff.output_n            <= REQ.write;
            end
            else if ((state_ff == ST_WRITE || state_ff == ST_READ) && !cnt_last)
                strobe_ff <= strobe_ff;
        end
    end

    // Address and write data held steady through turnaround
    // Straight from flops, so no decode glitch reaches the memory pins
    assign MEM_STROBE = strobe_ff;
    assign MEM_ADDR   = req_ff.addr;

    // ------------------------------------------------------------
    // Data bus drive
    // ------------------------------------------------------------
    // Enables kept in flops of their own, one per bit: an old lane set
    // meeting a new drive decision cannot glitch onto the pins
    // data held past terminating edge
    always_ff @(posedge CLK)
    begin
        if (RST)
            oe_n_ff <= {DATA_W{1'b1}};
        else if (CE)
        begin
            if (accept)
                oe_n_ff <= REQ.write ? ~lane_mask(REQ.lanes) : {DATA_W{1'b1}};
            // Released one cycle after the strobes, past the write end
            else if (state_ff == ST_TURN)
                oe_n_ff <= {DATA_W{1'b1}};
        end
    end

    assign MEM_DQ_OUT  = req_ff.wdata;
    assign MEM_DQ_OE_N = oe_n_ff;

    // ------------------------------------------------------------
    // Read capture
    // ------------------------------------------------------------
    // undriven lanes read as zero
    // sample only while enabled
    // Capture and strobe release share one edge; the sampler's delay means
    // the word taken was on the pins well before the strobes let go
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            RSP_VALID <= 1'b0;
            RSP       <= '0;
        end
        else if (CE)
        begin
            RSP_VALID <= 1'b0;
            if (state_ff == ST_READ && cnt_last)
            begin
                RSP_VALID     <= 1'b1;
                RSP.rdata     <= dq_sync & lane_mask(req_ff.lanes);
                // A lane-less read has nothing driven, so it reports no correction
                // error flag captured
                RSP.corrected <= err_sync & (|req_ff.lanes);
            end
        end
    end

endmodule

/* File: bench/sram_dev_model.sv */
`timescale 1ns/100ps
// Behavioural memory behind the pins, sixteen words deep
module sram_dev_model
(
    // Pins from the host
    input  wire sram_host_pkg::strobe_t           stb,
    input  wire logic [sram_host_pkg::ADDR_W-1:0] addr,
    input  wire logic [sram_host_pkg::DATA_W-1:0] bus,
    input  wire logic                             inject,
    // Pins back to the host
    output logic      [sram_host_pkg::DATA_W-1:0] dq,
    output logic      [sram_host_pkg::DATA_W-1:0] dq_oe_n,
    output logic                                  err
);
    import sram_host_pkg::*;
    // ------------------------------------------------------------
    // Array and decode
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [0:15];
    logic              sel;
    logic              wr;
    logic              rd;
    // Only the low four address bits decode; enough for the bench
    initial
    begin
        for (int i = 0; i < 16; i++)
            mem[i] = '0;
    end
    assign sel = !stb.select_low_active && stb.select_high_active;
    assign wr = sel && !stb.write_n && !(stb.upper_byte_strobe_n && stb.lower_byte_strobe_n);
    assign rd = sel && stb.write_n && !stb.output_n;
    assign dq_oe_n = ~{{LANE_W{rd && !stb.upper_byte_strobe_n}},
                       {LANE_W{rd && !stb.lower_byte_strobe_n}}};
    // Floating bits show the inverse, so a stale sample cannot pass
    assign dq = mem[addr[3:0]] ^ dq_oe_n;
    assign err = inject ^ (&dq_oe_n);
    always @*
    begin
        if (wr && !stb.lower_byte_strobe_n)
            mem[addr[3:0]][7:0] = bus[7:0];
        if (wr && !stb.upper_byte_strobe_n)
            mem[addr[3:0]][15:8] = bus[15:8];
    end
endmodule

/* File: bench/sram_host_chk.sv */
`timescale 1ns/100ps
// Pin timing watcher for the memory host
module sram_host_chk
(
    // Clock and reset
    input  wire logic                             CLK,
    input  wire logic                             RST,
    // Watched outputs
    input  wire logic                             RSP_VALID,
    input  wire sram_host_pkg::strobe_t           MEM_STROBE,
    input  wire logic [sram_host_pkg::DATA_W-1:0] MEM_DQ_OUT,
    input  wire logic [sram_host_pkg::DATA_W-1:0] MEM_DQ_OE_N
);
    import sram_host_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    logic wn;
    logic on;
    logic sel;
    logic nob;
    assign wn = MEM_STROBE.write_n;
    assign on = MEM_STROBE.output_n;
    assign sel = !MEM_STROBE.select_low_active && MEM_STROBE.select_high_active;
    assign nob = MEM_STROBE.upper_byte_strobe_n && MEM_STROBE.lower_byte_strobe_n;
    // Write strobe low for nine cycles, then released
    sequence s_write_held;
        !wn [*8] ##1 !wn ##1 wn;
    endsequence
    chk_write_start: assert property ($fell(wn) |-> sel && !nob)
        else $error("write strobe fell without select or byte strobe");
    chk_write_width: assert property ($fell(wn) |-> s_write_held)
        else $error("write strobe low time wrong");
    chk_write_end: assert property ($rose(wn) |-> !sel && nob && $stable(MEM_DQ_OUT))
        else $error("write not ended by all strobes with data held");
    chk_read_float: assert property (!on |-> &MEM_DQ_OE_N)
        else $error("host drives data during read");
    chk_select_level: assert property (MEM_STROBE.select_low_active ==
        !MEM_STROBE.select_high_active)
        else $error("select pins in mixed state");
    chk_lane_drive: assert property (!wn |-> MEM_DQ_OE_N ==
        {{8{MEM_STROBE.upper_byte_strobe_n}}, {8{MEM_STROBE.lower_byte_strobe_n}}})
        else $error("driven lanes differ from byte strobes");
    chk_read_answer: assert property ($rose(on) |-> RSP_VALID && wn)
        else $error("read end without response");
    chk_read_width: assert property ($fell(on) |-> ##14 $rose(on))
        else $error("read strobe low time wrong");
endmodule
bind sram_host sram_host_chk u_chk (.CLK(CLK), .RST(RST), .RSP_VALID(RSP_VALID),
    .MEM_STROBE(MEM_STROBE), .MEM_DQ_OUT(MEM_DQ_OUT), .MEM_DQ_OE_N(MEM_DQ_OE_N));

/* File: bench/testbench.sv */
`timescale 1ns/100ps
// Random reads and writes through the host into the memory model
module testbench;
    import sram_host_pkg::*;
    logic              CLK, RST, CE, REQ_VALID, REQ_READY, RSP_VALID, MEM_ERR, inject;
    req_t              REQ;
    rsp_t              RSP;
    strobe_t           MEM_STROBE;
    logic [ADDR_W-1:0] MEM_ADDR;
    logic [DATA_W-1:0] MEM_DQ_IN, MEM_DQ_OUT, MEM_DQ_OE_N, dev_dq, dev_oe_n;
    logic [DATA_W-1:0] shadow [0:15];
    int                errors, check_count, cycles;
    // Wire level: host bits where it drives, model or float pattern elsewhere
    assign MEM_DQ_IN = (MEM_DQ_OUT & ~MEM_DQ_OE_N) | (dev_dq & MEM_DQ_OE_N);
    sram_host u_dut (.CLK(CLK), .RST(RST), .CE(CE), .REQ_VALID(REQ_VALID),
        .REQ_READY(REQ_READY), .REQ(REQ), .RSP_VALID(RSP_VALID), .RSP(RSP),
        .MEM_STROBE(MEM_STROBE), .MEM_ADDR(MEM_ADDR), .MEM_DQ_IN(MEM_DQ_IN),
        .MEM_DQ_OUT(MEM_DQ_OUT), .MEM_DQ_OE_N(MEM_DQ_OE_N), .MEM_ERR(MEM_ERR));
    sram_dev_model u_mem (.stb(MEM_STROBE), .addr(MEM_ADDR), .bus(MEM_DQ_IN),
        .inject(inject), .dq(dev_dq), .dq_oe_n(dev_oe_n), .err(MEM_ERR));
    initial
    begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    function automatic logic [15:0] lane_mask(input logic [1:0] ln);
        return {{8{ln[1]}}, {8{ln[0]}}};
    endfunction
    task automatic finish_test();
        if (errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One request; a read waits its response, bounded
    task automatic access(input logic wr, input logic [1:0] ln, input logic [3:0] a,
                          input logic [15:0] d, input logic inj);
        int n;
        REQ_VALID <= 1'b1;
        REQ <= '{wr, ln, {14'h0, a}, d};
        inject <= inj;
        do @(posedge CLK); while (REQ_READY !== 1'b1);
        REQ_VALID <= 1'b0;
        if (wr)
            shadow[a] = (shadow[a] & ~lane_mask(ln)) | (d & lane_mask(ln));
        n = 0;
        while (!wr && RSP_VALID !== 1'b1 && n < 40)
        begin
            @(posedge CLK);
            n++;
        end
        if (!wr)
        begin
            check("read data", RSP.rdata, shadow[a] & lane_mask(ln));
            check("error flag", {15'h0, RSP.corrected}, {15'h0, inj});
        end
        // Let an edge pass so the next call never re-drives in this step
        @(posedge CLK);
    endtask
    // Hang guard, well above sixty-five accesses of twenty cycles;
    // each cycle out of reset also checks host and memory never both drive
    always @(posedge CLK)
    begin
        cycles <= cycles + 1;
        if (!RST)
            check("bus contention", ~MEM_DQ_OE_N & ~dev_oe_n, 16'h0000);
        if (cycles == 5000)
        begin
            errors++;
            finish_test();
        end
    end
    initial
    begin
        logic w;
        RST = 1'b1;
        CE = 1'b1;
        REQ_VALID = 1'b0;
        REQ = '0;
        inject = 1'b0;
        errors = 0;
        check_count = 0;
        cycles = 0;
        for (int i = 0; i < 16; i++)
            shadow[i] = '0;
        void'($urandom(28682));
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        // Corners: lane writes back to back, standby write, clean and corrected reads
        access(1'b1, 2'b11, 4'h3, 16'ha55a, 1'b0);
        access(1'b1, 2'b01, 4'h3, 16'h12c3, 1'b1);
        access(1'b1, 2'b00, 4'h3, 16'hffff, 1'b0);
        access(1'b0, 2'b11, 4'h3, 16'h0000, 1'b1);
        access(1'b0, 2'b10, 4'h3, 16'h0000, 1'b0);
        // Reset again mid-run: idle strobes and ready on the first edge out
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        check("strobes after reset", {10'h0, MEM_STROBE}, {10'h0, STROBE_IDLE});
        check("ready after reset", {15'h0, REQ_READY}, 16'h0001);
        repeat (60)
        begin
            w = 1'($urandom);
            access(w, w ? 2'($urandom) : 2'(1 + $urandom % 3), 4'($urandom),
                   16'($urandom), 1'($urandom));
        end
        finish_test();
    end
endmodule
